/* hw/dts_pkg.sv */
// Constants for the dual timer block: register indices, bit fields, reset values
package dts_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] DTS_IDX_RUN  = 8'h88; // timer_run_flag_control
  localparam logic [7:0] DTS_IDX_MODE = 8'h89; // timer_mode_control
  localparam logic [7:0] DTS_IDX_TL0  = 8'h8A; // timer_zero_low_byte
  localparam logic [7:0] DTS_IDX_TL1  = 8'h8B; // timer_one_low_byte
  localparam logic [7:0] DTS_IDX_TH0  = 8'h8C; // timer_zero_high_byte
  localparam logic [7:0] DTS_IDX_TH1  = 8'h8D; // timer_one_high_byte
  localparam logic [7:0] DTS_IDX_PRE  = 8'h8F; // count_prescale_value
  localparam logic [7:0] DTS_IDX_OUT  = 8'h91; // timer_output_control
  localparam int         DTS_AW       = 12;    // APB address width
  // Run/flag control bits
  localparam int DTS_TF1 = 7;
  localparam int DTS_TR1 = 6;
  localparam int DTS_TF0 = 5;
  localparam int DTS_TR0 = 4;
  localparam int DTS_IE1 = 3;
  localparam int DTS_IT1 = 2;
  localparam int DTS_IE0 = 1;
  localparam int DTS_IT0 = 0;
  // Mode control fields
  localparam int DTS_TIMER_ONE_GATING = 7;
  localparam int DTS_CT1   = 6;
  localparam int DTS_M1_HI = 5;
  localparam int DTS_M1_LO = 4;
  localparam int DTS_TIMER_ZERO_GATING = 3;
  localparam int DTS_CT0   = 2;
  localparam int DTS_M0_HI = 1;
  localparam int DTS_M0_LO = 0;
  // Output control bits
  localparam int DTS_T1OE = 7;
  localparam int DTS_TIMER_ZERO_TOGGLE_ENABLE = 6;
  localparam int DTS_SERIAL_SPI_VARIANT_ENABLE = 5;
  localparam logic [7:0] DTS_OUT_MASK = 8'hE0; // Implemented output bits
  // Timer modes
  localparam logic [1:0] DTS_M_13BIT  = 2'h0;
  localparam logic [1:0] DTS_M_16BIT  = 2'h1;
  localparam logic [1:0] DTS_M_RELOAD = 2'h2;
  localparam logic [1:0] DTS_M_SPLIT  = 2'h3;
  // Reset values
  localparam logic [7:0] DTS_RST_BYTE = 8'h00;
  localparam logic [3:0] DTS_RST_PRE  = 4'h0;
  // APB slave states
  typedef enum logic [1:0] {
    DTS_AP_IDLE = 2'b01,
    DTS_AP_DONE = 2'b10
  } dts_apb_t;
endpackage

/* hw/dts_timer.sv */
// Dual 8051-class timer/counter with APB register access and pin toggle
//
// Overview of operation
// - Timer one mode 3 freezes its count
// - Timer zero mode 3 low byte own counter
// - Split high byte counts clocks, sets one-flag
// - Timer one in split never raises overflow flag
// - Timer one mode 3 stops its toggle
// - Overflow flags set on overflow, cleared on vector
// - Run bits enable each timer
// - External edge flags set on detected edge
// - Type bit: falling edge or low level
// - Output enables toggle counter pins on overflow
// - Serial SPI variant bit, used outside
// - Toggle mode keeps flags and baud tick
// - Gate low halts counting and toggling
// - Mode 2 toggle gives half-duty clock
// - Gate bit requires pin high plus run
// - Source select: clock or counter pin
// - Mode 0 is 13-bit with 5-bit prescale
// - Modes 1 and 2; timer one mode 3 stops
// - Timer zero mode 3 splits the bytes
// - Counter counts sampled falling pin edges
// - Reload low byte from high byte on overflow
`timescale 1ns/1ps
`default_nettype none
module dts_timer
  import dts_pkg::*;
(
  input  wire logic                       clock_in,         // 250 MHz clock
  input  wire logic                       rst_in,           // Sync reset, high
  input  wire logic                       psel_in,          // APB select
  input  wire logic                       penable_in,       // APB enable
  input  wire logic                       pwrite_in,        // APB write
  input  wire logic [dts_pkg::DTS_AW-1:0] paddr_in,         // APB byte address
  input  wire logic [31:0]                pwdata_in,        // APB write data
  output logic      [31:0]                prdata_out,       // APB read data
  output logic                            pready_out,       // APB ready
  output logic                            pslverr_out,      // APB error
  input  wire logic                       ext_irq_zero_pin_in, // Gate/irq 0
  input  wire logic                       ext_irq_one_pin_in,  // Gate/irq 1
  input  wire logic                       timer_zero_counter_pin_in, // Count 0
  input  wire logic                       timer_one_counter_pin_in,  // Count 1
  input  wire logic                       timer_zero_vector_in, // Vector ack
  input  wire logic                       timer_one_vector_in,  // Vector ack
  input  wire logic                       ext_irq_zero_vector_in, // Ack
  input  wire logic                       ext_irq_one_vector_in,  // Ack
  output logic                            timer_zero_overflow_flag_out, // Flag
  output logic                            timer_one_overflow_flag_out,  // Flag
  output logic                            ext_irq_zero_edge_flag_out,   // Flag
  output logic                            ext_irq_one_edge_flag_out,    // Flag
  output logic                            timer_zero_toggle_out, // Pin level
  output logic                            timer_one_toggle_out,  // Pin level
  output logic                            timer_one_baud_tick_out, // Pulse
  output logic                            serial_spi_variant_enable_out // Level
);
  import dts_pkg::*;

  // One counting step; returns {overflow, high, low}
  function automatic logic [16:0] dts_step(input logic [1:0] m,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (m)
      DTS_M_13BIT: begin
        r[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == 5'h1F) begin
          r[15:8] = hi + 8'h01;
          r[16]   = (hi == 8'hFF);
        end
      end
      DTS_M_16BIT: begin
        r = {1'b0, hi, lo} + 17'h00001;
      end
      DTS_M_RELOAD: begin
        if (lo == 8'hFF) begin
          r[7:0] = hi;
          r[16]  = 1'b1;
        end else begin
          r[7:0] = lo + 8'h01;
        end
      end
      default: begin
        r[7:0] = lo + 8'h01;
        r[16]  = (lo == 8'hFF);
      end
    endcase
    return r;
  endfunction

  // Register state
  logic [7:0] run_q;      // timer_run_flag_control
  logic [7:0] mode_q;     // timer_mode_control
  logic [7:0] outc_q;     // timer_output_control
  logic [3:0] pre_q;      // count_prescale_value
  logic [7:0] tl0_q;      // timer_zero_low_byte
  logic [7:0] th0_q;      // timer_zero_high_byte
  logic [7:0] tl1_q;      // timer_one_low_byte
  logic [7:0] th1_q;      // timer_one_high_byte
  logic [3:0] pcnt_q;     // Prescaler counter
  logic       tick;       // Shared count tick
  dts_apb_t   ap_q;       // APB slave state

  // Bus decode
  logic       acc;        // Access phase
  logic       wr;         // Write takes effect
  logic [7:0] idx;        // Register index
  logic       hit;        // Mapped address
  logic [7:0] rsel;       // Read mux byte
  assign acc = psel_in & penable_in;
  assign wr  = acc & pwrite_in & pready_out & hit;
  assign idx = paddr_in[9:2];

  // Address decode and read mux; bits above the byte read zero
  always_comb begin
    hit  = (paddr_in[1:0] == 2'h0) & (paddr_in[DTS_AW-1:10] == 2'h0);
    rsel = 8'h00;
    case (idx)
      DTS_IDX_RUN:  rsel = run_q;
      DTS_IDX_MODE: rsel = mode_q;
      DTS_IDX_TL0:  rsel = tl0_q;
      DTS_IDX_TL1:  rsel = tl1_q;
      DTS_IDX_TH0:  rsel = th0_q;
      DTS_IDX_TH1:  rsel = th1_q;
      DTS_IDX_PRE:  rsel = {4'h0, pre_q};
      DTS_IDX_OUT:  rsel = outc_q & DTS_OUT_MASK;
      default:      hit  = 1'b0;
    endcase
  end

  // APB answer: one wait state so the read data comes from a flop
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ap_q        <= DTS_AP_IDLE;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end else begin
      case (ap_q)
        DTS_AP_IDLE: begin
          if (acc) begin
            ap_q        <= DTS_AP_DONE;
            pready_out  <= 1'b1;
            pslverr_out <= ~hit;
            prdata_out  <= {24'h000000, rsel};
          end
        end
        DTS_AP_DONE: begin
          ap_q        <= DTS_AP_IDLE;
          pready_out  <= 1'b0;
          pslverr_out <= 1'b0;
        end
        default: begin
          ap_q       <= DTS_AP_IDLE;
          pready_out <= 1'b0;
        end
      endcase
    end
  end

  // Read/write configuration registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mode_q <= DTS_RST_BYTE;
      outc_q <= DTS_RST_BYTE;
      pre_q  <= DTS_RST_PRE;
    end else if (wr) begin
      if (idx == DTS_IDX_MODE) mode_q <= pwdata_in[7:0];
      if (idx == DTS_IDX_OUT)  outc_q <= pwdata_in[7:0] & DTS_OUT_MASK;
      if (idx == DTS_IDX_PRE)  pre_q  <= pwdata_in[3:0];
    end
  end
  assign serial_spi_variant_enable_out = outc_q[DTS_SERIAL_SPI_VARIANT_ENABLE];

  // Shared prescaler: one tick every pre_q+1 cycles
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pcnt_q <= 4'h0;
    end else if (pcnt_q >= pre_q) begin
      pcnt_q <= 4'h0;
    end else begin
      pcnt_q <= pcnt_q + 4'h1;
    end
  end
  assign tick = (pcnt_q >= pre_q);

  // Counter pin samples, taken once per tick
  logic cp0_q; // Timer zero pin sample
  logic cp1_q; // Timer one pin sample
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cp0_q <= 1'b0;
      cp1_q <= 1'b0;
    end else if (tick) begin
      cp0_q <= timer_zero_counter_pin_in;
      cp1_q <= timer_one_counter_pin_in;
    end
  end

  // Run decisions and count enables
  logic [1:0] m0;    // Timer zero mode
  logic [1:0] m1;    // Timer one mode
  logic       split; // Timer zero split mode
  logic       src0;  // Timer zero source event
  logic       src1;  // Timer one source event
  logic       en0;   // Timer zero low or whole count
  logic       en1;   // Timer one count
  logic       enh0;  // Split high byte count
  assign m0    = {mode_q[DTS_M0_HI], mode_q[DTS_M0_LO]};
  assign m1    = {mode_q[DTS_M1_HI], mode_q[DTS_M1_LO]};
  assign split = (m0 == DTS_M_SPLIT);
  // Source: every tick, or a sampled falling edge on the counter pin
  assign src0 = mode_q[DTS_CT0] ? (cp0_q & ~timer_zero_counter_pin_in) : 1'b1;
  assign src1 = mode_q[DTS_CT1] ? (cp1_q & ~timer_one_counter_pin_in) : 1'b1;
  // Gate keeps working with toggle output, so a low gate also stops the pin
  assign en0 = tick & src0 & run_q[DTS_TR0]
             & (~mode_q[DTS_TIMER_ZERO_GATING] | ext_irq_zero_pin_in);
  assign en1 = tick & src1 & run_q[DTS_TR1] & (m1 != DTS_M_SPLIT)
             & (~mode_q[DTS_TIMER_ONE_GATING] | ext_irq_one_pin_in);
  assign enh0 = tick & split & run_q[DTS_TR1];

  // Step results
  logic [16:0] s0;   // Timer zero step
  logic [16:0] s1;   // Timer one step
  logic        ov0;  // Timer zero overflow event
  logic        ov1;  // Timer one overflow event
  logic        ovh0; // Split high byte overflow
  assign s0   = dts_step(m0, tl0_q, th0_q);
  assign s1   = dts_step(m1, tl1_q, th1_q);
  assign ov0  = en0 & s0[16];
  assign ov1  = en1 & s1[16];
  assign ovh0 = enh0 & (th0_q == 8'hFF);

  // Timer zero count bytes; a bus write wins over counting
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tl0_q <= DTS_RST_BYTE;
      th0_q <= DTS_RST_BYTE;
    end else begin
      if (en0) begin
        tl0_q <= s0[7:0];
        if (!split) th0_q <= s0[15:8];
      end
      if (enh0) th0_q <= th0_q + 8'h01;
      if (wr && idx == DTS_IDX_TL0) tl0_q <= pwdata_in[7:0];
      if (wr && idx == DTS_IDX_TH0) th0_q <= pwdata_in[7:0];
    end
  end

  // Timer one count bytes; mode 3 simply holds them
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tl1_q <= DTS_RST_BYTE;
      th1_q <= DTS_RST_BYTE;
    end else begin
      if (en1) begin
        tl1_q <= s1[7:0];
        th1_q <= s1[15:8];
      end
      if (wr && idx == DTS_IDX_TL1) tl1_q <= pwdata_in[7:0];
      if (wr && idx == DTS_IDX_TH1) th1_q <= pwdata_in[7:0];
    end
  end

  // External interrupt pin history for edge detection
  logic xp0_q; // Irq zero pin, last cycle
  logic xp1_q; // Irq one pin, last cycle
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      xp0_q <= 1'b1;
      xp1_q <= 1'b1;
    end else begin
      xp0_q <= ext_irq_zero_pin_in;
      xp1_q <= ext_irq_one_pin_in;
    end
  end

  // Flag set terms
  logic set_tf0; // Timer zero overflow
  logic set_tf1; // Timer one flag source
  logic set_ie0; // Irq zero event
  logic set_ie1; // Irq one event
  assign set_tf0 = ov0;
  // In split mode the high byte owns the flag; timer one cannot raise it
  assign set_tf1 = split ? ovh0 : ov1;
  assign set_ie0 = run_q[DTS_IT0] ? (xp0_q & ~ext_irq_zero_pin_in)
                                  : ~ext_irq_zero_pin_in;
  assign set_ie1 = run_q[DTS_IT1] ? (xp1_q & ~ext_irq_one_pin_in)
                                  : ~ext_irq_one_pin_in;

  // Run/flag register: software writes, hardware sets win over clears
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      run_q <= DTS_RST_BYTE;
    end else begin
      if (wr && idx == DTS_IDX_RUN) begin
        run_q <= pwdata_in[7:0];
      end else begin
        if (timer_zero_vector_in)   run_q[DTS_TF0] <= 1'b0;
        if (timer_one_vector_in)    run_q[DTS_TF1] <= 1'b0;
        if (ext_irq_zero_vector_in) run_q[DTS_IE0] <= 1'b0;
        if (ext_irq_one_vector_in)  run_q[DTS_IE1] <= 1'b0;
      end
      if (set_tf0) run_q[DTS_TF0] <= 1'b1;
      if (set_tf1) run_q[DTS_TF1] <= 1'b1;
      if (set_ie0) run_q[DTS_IE0] <= 1'b1;
      if (set_ie1) run_q[DTS_IE1] <= 1'b1;
    end
  end
  assign timer_zero_overflow_flag_out = run_q[DTS_TF0];
  assign timer_one_overflow_flag_out  = run_q[DTS_TF1];
  assign ext_irq_zero_edge_flag_out   = run_q[DTS_IE0];
  assign ext_irq_one_edge_flag_out    = run_q[DTS_IE1];

  // Toggle outputs; in mode 2 this gives a half-duty clock
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      timer_zero_toggle_out <= 1'b0;
      timer_one_toggle_out  <= 1'b0;
    end else begin
      if (ov0 && outc_q[DTS_TIMER_ZERO_TOGGLE_ENABLE]) timer_zero_toggle_out <= ~timer_zero_toggle_out;
      if (ov1 && outc_q[DTS_T1OE]) timer_one_toggle_out <= ~timer_one_toggle_out;
    end
  end

  // Baud tick keeps running in split and toggle modes
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      timer_one_baud_tick_out <= 1'b0;
    end else begin
      timer_one_baud_tick_out <= ov1;
    end
  end

  // Helper for assertions: any count byte written
  logic cwr; // Count byte write this cycle
  assign cwr = wr & (idx >= DTS_IDX_TL0) & (idx <= DTS_IDX_TH1);

  a_t1_mode3_hold: assert property (@(posedge clock_in) disable iff (rst_in)
    (m1 == DTS_M_SPLIT && !cwr) |=> ($stable(tl1_q) && $stable(th1_q)))
    else $error("timer one moved in mode 3");
  a_tf0_on_ovf: assert property (@(posedge clock_in) disable iff (rst_in)
    ov0 |=> run_q[DTS_TF0])
    else $error("timer zero flag not set on overflow");
  a_split_tf1: assert property (@(posedge clock_in) disable iff (rst_in)
    (split && enh0 && th0_q == 8'hFF) |=> run_q[DTS_TF1])
    else $error("split high byte did not set timer one flag");
  a_split_no_t1: assert property (@(posedge clock_in) disable iff (rst_in)
    (split && ov1 && !ovh0 && !run_q[DTS_TF1] && !wr) |=> !run_q[DTS_TF1])
    else $error("timer one raised flag in split mode");
  a_toggle_zero: assert property (@(posedge clock_in) disable iff (rst_in)
    (ov0 && outc_q[DTS_TIMER_ZERO_TOGGLE_ENABLE]) |=> (timer_zero_toggle_out != $past(timer_zero_toggle_out)))
    else $error("timer zero pin did not toggle");
  a_gate_halts: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode_q[DTS_TIMER_ZERO_GATING] && !ext_irq_zero_pin_in && !cwr) |=> $stable(tl0_q))
    else $error("gated timer zero counted");
  a_out_reserved: assert property (@(posedge clock_in) disable iff (rst_in)
    (outc_q[4:0] == 5'h00))
    else $error("unused output bits not zero");
  a_tick_only: assert property (@(posedge clock_in) disable iff (rst_in)
    (!tick && !cwr) |=> ($stable(tl0_q) && $stable(th0_q) && $stable(tl1_q)))
    else $error("count moved without tick");
  a_reload: assert property (@(posedge clock_in) disable iff (rst_in)
    (m0 == DTS_M_RELOAD && ov0 && !cwr) |=> (tl0_q == th0_q && $stable(th0_q)))
    else $error("reload failed");
  a_apb_answer: assert property (@(posedge clock_in) disable iff (rst_in)
    (acc && !pready_out) |=> (pready_out ##1 !pready_out))
    else $error("apb answer not one cycle");
endmodule
`default_nettype wire

/* tb/dts_pin_model.sv */
// Pin-side partner: gate/irq pins and counter pin pulse source
`timescale 1ns/1ps
`default_nettype none
module dts_pin_model (
  input  wire logic       clock_in,      // Block clock
  input  wire logic       irq0_level_in, // Wanted level of irq pin 0
  input  wire logic       irq1_level_in, // Wanted level of irq pin 1
  input  wire logic [7:0] pulses_in,     // Falling edges to make on count pin 0
  input  wire logic       start_in,      // Load pulses_in
  output logic            irq0_pin_out,  // Gate/irq pin 0
  output logic            irq1_pin_out,  // Gate/irq pin 1
  output logic            cnt0_pin_out,  // Count pin 0
  output logic            cnt1_pin_out   // Count pin 1, idle
);
  logic [9:0] left_q; // Remaining phases, four per pulse

  // Each level holds two cycles so every sample sees it
  always @(posedge clock_in) begin
    if (start_in) begin
      left_q <= {pulses_in, 2'b00};
    end else if (left_q != 10'h000) begin
      left_q <= left_q - 10'h001;
    end
  end

  // Pins rest high as with a pull-up
  assign cnt0_pin_out = (left_q == 10'h000) ? 1'b1 : ~left_q[1];
  assign cnt1_pin_out = 1'b1;
  assign irq0_pin_out = irq0_level_in;
  assign irq1_pin_out = irq1_level_in;

  initial left_q = 10'h000;
endmodule
`default_nettype wire

/* tb/dual_timer_split_toggle_tb_top.sv */
// Self-checking testbench for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dual_timer_split_toggle_tb_top;
  import dts_pkg::*;
  logic              clock_in = 1'b0;  // 250 MHz
  logic              rst_in   = 1'b1;  // Sync reset
  logic              psel     = 1'b0;  // APB request
  logic              penable  = 1'b0;
  logic              pwrite   = 1'b0;
  logic [DTS_AW-1:0] paddr    = '0;
  logic [31:0]       pwdata   = 32'h0;
  logic [31:0]       prdata;
  logic              pready, pslverr;
  logic [3:0]        vec      = 4'h0;  // Vector acks: tf0, tf1, ie0, ie1
  logic              irq0_lvl = 1'b1;  // Wanted irq levels
  logic              irq1_lvl = 1'b1;
  logic              pstart   = 1'b0;  // Pulse burst start
  logic [7:0]        npulse   = 8'h00;
  wire logic         irq0_pin, irq1_pin, cnt0_pin, cnt1_pin;
  logic              tf0, tf1, ie0, ie1, tog0, tog1, baud, spi;
  logic [31:0]       rd;               // Last read data
  logic              serr;             // Last error response
  int errors = 0, num_checks = 0, tog_cnt = 0, tog1_cnt = 0, baud_cnt = 0;

  // Free-running clock
  always #2 clock_in = ~clock_in;

  // Edge counters for toggle pins and baud pulses
  // Baud is sampled mid-cycle so a counter reset on a rising edge never races it
  always @(tog0) tog_cnt = tog_cnt + 1;
  always @(tog1) tog1_cnt = tog1_cnt + 1;
  always @(negedge clock_in) if (baud === 1'b1) baud_cnt = baud_cnt + 1;

  dts_timer dut (
    .clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .ext_irq_zero_pin_in(irq0_pin), .ext_irq_one_pin_in(irq1_pin),
    .timer_zero_counter_pin_in(cnt0_pin), .timer_one_counter_pin_in(cnt1_pin),
    .timer_zero_vector_in(vec[0]), .timer_one_vector_in(vec[1]),
    .ext_irq_zero_vector_in(vec[2]), .ext_irq_one_vector_in(vec[3]),
    .timer_zero_overflow_flag_out(tf0), .timer_one_overflow_flag_out(tf1),
    .ext_irq_zero_edge_flag_out(ie0), .ext_irq_one_edge_flag_out(ie1),
    .timer_zero_toggle_out(tog0), .timer_one_toggle_out(tog1),
    .timer_one_baud_tick_out(baud), .serial_spi_variant_enable_out(spi));

  dts_pin_model pins (
    .clock_in(clock_in), .irq0_level_in(irq0_lvl), .irq1_level_in(irq1_lvl),
    .pulses_in(npulse), .start_in(pstart), .irq0_pin_out(irq0_pin),
    .irq1_pin_out(irq1_pin), .cnt0_pin_out(cnt0_pin), .cnt1_pin_out(cnt1_pin));

  // Verdict and end of run
  task automatic end_of_test();
    if (errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; a hung slave is caught by the watchdog
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] data);
    @(posedge clock_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
    paddr <= DTS_AW'({idx, 2'b00}); pwdata <= {24'h0, data};
    @(posedge clock_in);
    penable <= 1'b1;
    do begin
      @(posedge clock_in);
    end while (pready !== 1'b1);
    rd = prdata; serr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d); apb(1'b1, idx, d); endtask
  task automatic cyc(input int n); repeat (n) @(posedge clock_in); endtask

  // Vector acknowledge pulse, then let the flag settle
  task automatic vpulse(input int i);
    @(posedge clock_in); vec[i] <= 1'b1;
    @(posedge clock_in); vec[i] <= 1'b0;
    cyc(2);
  endtask

  // Reset values, unmapped place, unused output bits
  task automatic t_reset();
    chk("flags", 8'h00, {tf0, tf1, ie0, ie1, tog0, tog1, baud, spi});
    apb(1'b0, DTS_IDX_RUN, 8'h00); chk("run rst", 32'h0, rd);
    apb(1'b0, DTS_IDX_MODE, 8'h00); chk("mode rst", 32'h0, rd);
    apb(1'b0, 8'h90, 8'h00); chk("unmapped", 32'h00000001, {rd[30:0], serr});
    wr(DTS_IDX_OUT, 8'hFF); apb(1'b0, DTS_IDX_OUT, 8'h00); chk("out ctl", 32'hE0, rd);
    chk("spi", 1, spi);
    wr(DTS_IDX_OUT, 8'h00);
  endtask

  // 13-bit mode wrap, run bit, vector clear
  task automatic t_mode0();
    wr(DTS_IDX_PRE, 8'h00); wr(DTS_IDX_MODE, 8'h00);
    wr(DTS_IDX_TL0, 8'h1E); wr(DTS_IDX_TH0, 8'hFF);
    cyc(10); chk("tf0 idle", 0, tf0);
    wr(DTS_IDX_RUN, 8'h10); cyc(4); chk("tf0 wrap", 1, tf0);
    wr(DTS_IDX_RUN, 8'h20); chk("tf0 kept", 1, tf0);
    vpulse(0); chk("tf0 clr", 0, tf0);
  endtask

  // Both timers reload mode with pin toggle, timer source kept
  task automatic t_toggle();
    wr(DTS_IDX_MODE, 8'h22);
    wr(DTS_IDX_TH0, 8'hFE); wr(DTS_IDX_TL0, 8'hFE);
    wr(DTS_IDX_TH1, 8'hFE); wr(DTS_IDX_TL1, 8'hFE);
    wr(DTS_IDX_OUT, 8'hC0); wr(DTS_IDX_RUN, 8'h50); cyc(2);
    tog_cnt = 0; tog1_cnt = 0; cyc(40);
    chk("tog0 edges", 20, tog_cnt);
    chk("tog1 edges", 20, tog1_cnt);
    chk("flags tog", 2'b11, {tf0, tf1});
    wr(DTS_IDX_RUN, 8'h00); wr(DTS_IDX_OUT, 8'h00); vpulse(0); vpulse(1);
    apb(1'b0, DTS_IDX_TH0, 8'h00); chk("reload kept", 32'hFE, rd);
  endtask

  // Gate pin halts and releases timer zero; level irq flag
  task automatic t_gate();
    wr(DTS_IDX_MODE, 8'h0A); wr(DTS_IDX_TL0, 8'h10);
    irq0_lvl <= 1'b0; wr(DTS_IDX_RUN, 8'h10); cyc(20);
    chk("ie0 level", 1, ie0);
    wr(DTS_IDX_RUN, 8'h00); apb(1'b0, DTS_IDX_TL0, 8'h00);
    chk("gated hold", 32'h10, rd);
    irq0_lvl <= 1'b1; wr(DTS_IDX_RUN, 8'h10); cyc(10); wr(DTS_IDX_RUN, 8'h00);
    apb(1'b0, DTS_IDX_TL0, 8'h00); chk("gate open", 32'h1E, rd);
    vpulse(2); chk("ie0 clr", 0, ie0);
  endtask

  // Edge-type irq: one set per falling edge
  task automatic t_edge();
    wr(DTS_IDX_RUN, 8'h05); irq0_lvl <= 1'b0; irq1_lvl <= 1'b0; cyc(3);
    chk("ie0 edge", 1, ie0);
    chk("ie1 edge", 1, ie1);
    vpulse(2); chk("ie0 no reset", 0, ie0);
    vpulse(3); chk("ie1 no reset", 0, ie1);
    irq0_lvl <= 1'b1; irq1_lvl <= 1'b1; wr(DTS_IDX_RUN, 8'h00);
  endtask

  // Counter source counts falling pin edges
  task automatic t_count();
    wr(DTS_IDX_MODE, 8'h05); wr(DTS_IDX_TL0, 8'h00); wr(DTS_IDX_TH0, 8'h00);
    wr(DTS_IDX_RUN, 8'h10);
    @(posedge clock_in); npulse <= 8'h03; pstart <= 1'b1;
    @(posedge clock_in); pstart <= 1'b0;
    cyc(20); wr(DTS_IDX_RUN, 8'h00);
    apb(1'b0, DTS_IDX_TL0, 8'h00); chk("pin count", 32'h03, rd);
  endtask

  // Split mode, timer one kept silent, stop and restart
  task automatic t_split();
    wr(DTS_IDX_MODE, 8'h23); wr(DTS_IDX_TL0, 8'h00); wr(DTS_IDX_TH0, 8'hF0);
    wr(DTS_IDX_TH1, 8'hFE); wr(DTS_IDX_TL1, 8'hFE);
    wr(DTS_IDX_RUN, 8'h40); cyc(30);
    chk("tf1 by high byte", 1, tf1);
    chk("tf0 split", 0, tf0);
    wr(DTS_IDX_TH0, 8'h00); vpulse(1);
    baud_cnt = 0; cyc(40);
    chk("tf1 silent", 0, tf1);
    chk("baud split", 20, baud_cnt);
    apb(1'b0, DTS_IDX_TL0, 8'h00); chk("low byte idle", 32'h0, rd);
    wr(DTS_IDX_MODE, 8'h33); apb(1'b0, DTS_IDX_TL1, 8'h00);
    serr = rd[0]; cyc(4); baud_cnt = 0; cyc(10);
    chk("t1 frozen", 0, baud_cnt);
    apb(1'b0, DTS_IDX_TL1, 8'h00); chk("t1 hold", serr, rd[0]);
    wr(DTS_IDX_TL1, 8'hFF); wr(DTS_IDX_MODE, 8'h23); baud_cnt = 0; cyc(10);
    chk("t1 restart", 5, baud_cnt);
    wr(DTS_IDX_RUN, 8'h00); vpulse(1);
  endtask

  // Shared prescaler sets the count rate
  task automatic t_presc();
    wr(DTS_IDX_MODE, 8'h01); wr(DTS_IDX_TL0, 8'h00); wr(DTS_IDX_TH0, 8'h00);
    wr(DTS_IDX_PRE, 8'h03); wr(DTS_IDX_RUN, 8'h10); cyc(40); wr(DTS_IDX_RUN, 8'h00);
    apb(1'b0, DTS_IDX_TL0, 8'h00);
    chk("prescaled", 32'h0B, rd);
    wr(DTS_IDX_PRE, 8'h00);
  endtask

  // Watchdog against a hung handshake
  initial begin
    #100000;
    errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset();
    t_mode0();
    t_toggle();
    t_gate();
    t_edge();
    t_count();
    t_split();
    t_presc();
    end_of_test();
  end
endmodule
`default_nettype wire
